// file: vec_pkg.sv
package vec_pkg;

  localparam logic [5:0]  PRIMARY_OPC     = 6'h04;
  // Extended opcodes, 11 bits.
  localparam logic [10:0] XO_WHE_D        = 11'h311;
  localparam logic [10:0] XO_WHE_X        = 11'h310;
  localparam logic [10:0] XO_WHOU_D       = 11'h315;
  localparam logic [10:0] XO_WHOU_X       = 11'h314;
  localparam logic [10:0] XO_WHOS_D       = 11'h317;
  localparam logic [10:0] XO_WHOS_X       = 11'h316;
  localparam logic [10:0] XO_WHSPLAT_D    = 11'h31D;
  localparam logic [10:0] XO_WHSPLAT_X    = 11'h31C;
  localparam logic [10:0] XO_WWSPLAT_D    = 11'h319;
  localparam logic [10:0] XO_WWSPLAT_X    = 11'h318;
  localparam logic [10:0] XO_MERGE_HI     = 11'h22C;
  localparam logic [10:0] XO_MERGE_LO     = 11'h22D;
  localparam logic [10:0] XO_MERGE_HILO   = 11'h22E;
  localparam logic [10:0] XO_MERGE_LOHI   = 11'h22F;
  localparam logic [10:0] XO_GUARD_MAC    = 11'h52B;

  localparam logic [1:0]  OFFSET_SHIFT    = 2'h2;
  localparam logic [31:0] ADDR_HALF_STEP  = 32'h0000_0002;
  localparam logic [63:0] RESULT_RESET    = 64'h0;
  localparam logic [63:0] ACC_RESET       = 64'h0;

  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_WHE     = 4'h1,
    OP_WHOS    = 4'h2,
    OP_WHOU    = 4'h3,
    OP_WHSPLAT = 4'h4,
    OP_WWSPLAT = 4'h5,
    OP_MHI     = 4'h6,
    OP_MLO     = 4'h7,
    OP_MHILO   = 4'h8,
    OP_MLOHI   = 4'h9,
    OP_MAC     = 4'hA
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1
  } state_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] base_source_reg;
    logic [63:0] index_source_reg;
    logic [63:0] src_b;
  } issue_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [63:0] data;
    logic        acc_written;
  } result_t;

endpackage

// file: vec_load_merge_mac.sv
`timescale 1ns/1ns
// What this block does
// [RL1] Even load: halves at 0-15, 32-47, rest zero
// [RL2] Odd signed load sign-extends each half word
// [RL3] Odd unsigned load zero-fills upper halves
// [RL4] Half splat: each half fills one element
// [RL5] Word splat copies word into both elements
// [RL6] Displacement address adds offset field times four
// [RL7] Base register zero means base value zero
// [RL8] Indexed address adds full unscaled index value
// [RL9] Big endian keeps bytes in address order
// [RL10] Little endian swaps bytes of each half; a word splat here reverses all four bytes instead
// [RL11] High merge with equal sources splats high
// [RL12] Low merge with equal sources splats low
// [RL13] Low/high merge; equal sources swap elements
// [RL14] Four merges give any element pair
// [RL15] Guarded MAC adds sign-extended product, updates both
// [RL16] MAC multiplies signed fractional bits 32-47
// [RL17] MAC wraps modulo, flags no overflow
// [RL18] Decode by primary and extended opcode
// [RL19] High merge: high of first, high of second
module vec_load_merge_mac (
  input  wire logic            i_clk,
  input  wire logic            i_rstn,
  input  wire vec_pkg::issue_t i_issue,
  input  wire logic            i_little_endian,
  input  wire logic            i_mem_ready,
  input  wire logic [31:0]     i_mem_rdata,
  output logic                 o_busy,
  output logic                 o_mem_req,
  output logic [31:0]          o_mem_addr,
  output vec_pkg::result_t     o_result,
  output logic [63:0]          o_mac_running_total
);

  ////////////////////////////////////////////////////////////////////////////
  // Address and data helpers.

  // Puts one loaded half word into register order; little-endian mode
  // swaps its two bytes.
  function automatic logic [15:0] order_half(input logic [15:0] h,
                                             input logic        le);
    order_half = le ? {h[7:0], h[15:8]} : h; // RL9 RL10
  endfunction

  // Sign-extends one half word to a 32-bit element.
  function automatic logic [31:0] sext16(input logic [15:0] h);
    sext16 = {{16{h[15]}}, h};
  endfunction

  // A word splat reverses all four bytes in little-endian mode, not each
  // half on its own.
  function automatic logic [31:0] swap_word(input logic [31:0] w,
                                            input logic        le);
    swap_word = le ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

  // True for every load form, displacement and indexed alike.
  function automatic logic is_load_op(input vec_pkg::op_t o);
    is_load_op = (o == vec_pkg::OP_WHE) || (o == vec_pkg::OP_WHOS) ||
                 (o == vec_pkg::OP_WHOU) || (o == vec_pkg::OP_WHSPLAT) ||
                 (o == vec_pkg::OP_WWSPLAT);
  endfunction

  function automatic vec_pkg::op_t decode(input logic [31:0] ins);
    vec_pkg::op_t op;
    op = vec_pkg::OP_NONE;
    if (ins[31:26] == vec_pkg::PRIMARY_OPC) begin // RL18
      case (ins[10:0])
        vec_pkg::XO_WHE_D, vec_pkg::XO_WHE_X: begin
          op = vec_pkg::OP_WHE;
        end
        vec_pkg::XO_WHOS_D, vec_pkg::XO_WHOS_X: begin
          op = vec_pkg::OP_WHOS;
        end
        vec_pkg::XO_WHOU_D, vec_pkg::XO_WHOU_X: begin
          op = vec_pkg::OP_WHOU;
        end
        vec_pkg::XO_WHSPLAT_D, vec_pkg::XO_WHSPLAT_X: begin
          op = vec_pkg::OP_WHSPLAT;
        end
        vec_pkg::XO_WWSPLAT_D, vec_pkg::XO_WWSPLAT_X: begin
          op = vec_pkg::OP_WWSPLAT;
        end
        vec_pkg::XO_MERGE_HI: begin
          op = vec_pkg::OP_MHI;
        end
        vec_pkg::XO_MERGE_LO: begin
          op = vec_pkg::OP_MLO;
        end
        vec_pkg::XO_MERGE_HILO: begin
          op = vec_pkg::OP_MHILO;
        end
        vec_pkg::XO_MERGE_LOHI: begin
          op = vec_pkg::OP_MLOHI;
        end
        vec_pkg::XO_GUARD_MAC: begin
          op = vec_pkg::OP_MAC;
        end
        default: begin
          op = vec_pkg::OP_NONE;
        end
      endcase
    end
    return op;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Issue decode.

  // Decoded view of the offered instruction, valid in the same cycle.
  vec_pkg::op_t        op;
  logic                is_load;
  logic                is_disp;
  logic [31:0]         base_value;
  logic [31:0]         effective_address;
  logic [63:0]         merge_data;
  // Multiplier operands are signed half words.
  logic signed [15:0]  mul_a;
  logic signed [15:0]  mul_b;
  logic signed [31:0]  product;
  logic [31:0]         frac_product;
  logic [63:0]         mac_addend;
  logic [63:0]         mac_sum;

  always_comb begin
    op      = decode(i_issue.instr);
    is_load = is_load_op(op);
    // Displacement forms have the low extended-opcode bit set.
    is_disp = i_issue.instr[0];
    // Base register field zero selects a zero base.
    base_value = (i_issue.instr[20:16] == 5'h00) ? 32'h0000_0000
                                                 : i_issue.base_source_reg; // RL7
    if (is_disp) begin
      effective_address = base_value +
        {25'h0000000, i_issue.instr[15:11], 2'h0}; // RL6
    end else begin
      effective_address = base_value + i_issue.index_source_reg[31:0]; // RL8
    end
  end

  // Merges share one selector, so equal sources fall out naturally.
  always_comb begin
    case (op)
      vec_pkg::OP_MHI: begin
        // High element of each source.
        merge_data = {i_issue.index_source_reg[63:32],
                      i_issue.src_b[63:32]}; // RL11 RL19
      end
      vec_pkg::OP_MLO: begin
        // Low element of each source.
        merge_data = {i_issue.index_source_reg[31:0],
                      i_issue.src_b[31:0]}; // RL12 RL14
      end
      vec_pkg::OP_MHILO: begin
        // High element of the first, low element of the second.
        merge_data = {i_issue.index_source_reg[63:32],
                      i_issue.src_b[31:0]}; // RL14
      end
      default: begin
        // Low element of the first, high element of the second.
        merge_data = {i_issue.index_source_reg[31:0],
                      i_issue.src_b[63:32]}; // RL13
      end
    endcase
  end

  // The fractional product is the signed product shifted left by one.
  always_comb begin
    mul_a        = i_issue.index_source_reg[31:16]; // RL16
    mul_b        = i_issue.src_b[31:16]; // RL16
    product      = mul_a * mul_b;
    frac_product = {product[30:0], 1'b0};
    // The product is sign-extended before the add so that a negative
    // product lowers the total.
    mac_addend   = {{32{frac_product[31]}}, frac_product}; // RL15
    // Plain 64-bit add: wraps, no saturation and no status flag.
    mac_sum      = o_mac_running_total + mac_addend; // RL15 RL17
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencing: one 32-bit memory word per load.

  // Mode and target are captured at issue, so the issue bus may move on
  // while the word is fetched.
  vec_pkg::state_t state_reg;
  vec_pkg::op_t    load_op_reg;
  logic            load_le_reg;
  logic [4:0]      load_dest_reg;
  logic [15:0]     half0;
  logic [15:0]     half1;
  logic [31:0]     word_le;
  logic [63:0]     load_data;

  always_comb begin
    half0   = order_half(i_mem_rdata[31:16], load_le_reg);
    half1   = order_half(i_mem_rdata[15:0], load_le_reg);
    word_le = swap_word(i_mem_rdata, load_le_reg); // RL9 RL10
    // Lanes are numbered from the most significant end, so element zero
    // sits in data[63:32].
    case (load_op_reg)
      vec_pkg::OP_WHE: begin
        load_data = {half0, 16'h0000, half1, 16'h0000}; // RL1
      end
      vec_pkg::OP_WHOS: begin
        load_data = {sext16(half0), sext16(half1)}; // RL2
      end
      vec_pkg::OP_WHOU: begin
        load_data = {16'h0000, half0, 16'h0000, half1}; // RL3
      end
      vec_pkg::OP_WHSPLAT: begin
        load_data = {half0, half0, half1, half1}; // RL4
      end
      vec_pkg::OP_WWSPLAT: begin
        load_data = {word_le, word_le}; // RL5
      end
      default: begin
        load_data = vec_pkg::RESULT_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg     <= vec_pkg::ST_IDLE;
      load_op_reg   <= vec_pkg::OP_NONE;
      load_le_reg   <= 1'b0;
      load_dest_reg <= 5'h00;
      o_mem_req     <= 1'b0;
      o_mem_addr    <= 32'h0000_0000;
      o_busy        <= 1'b0;
    end else begin
      case (state_reg)
        vec_pkg::ST_IDLE: begin
          // A load is accepted only from idle.
          if (i_issue.valid && is_load) begin
            state_reg     <= vec_pkg::ST_LOAD;
            load_op_reg   <= op;
            load_le_reg   <= i_little_endian;
            load_dest_reg <= i_issue.instr[25:21];
            o_mem_req     <= 1'b1;
            o_mem_addr    <= effective_address;
            o_busy        <= 1'b1;
          end
        end
        vec_pkg::ST_LOAD: begin
          // Request, address and busy hold until the memory answers.
          if (i_mem_ready) begin
            state_reg <= vec_pkg::ST_IDLE;
            o_mem_req <= 1'b0;
            o_busy    <= 1'b0;
          end
        end
        default: begin
          // An illegal state falls back to idle and drops the request.
          state_reg <= vec_pkg::ST_IDLE;
          o_mem_req <= 1'b0;
          o_busy    <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and accumulator.

  // An issue offered while a load is outstanding is dropped, not queued.
  logic issue_ok;
  assign issue_ok = i_issue.valid && (state_reg == vec_pkg::ST_IDLE);

  // A load result appears in the cycle after ready; merge and accumulate
  // results one cycle after issue.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_result <= '0;
    end else if (state_reg == vec_pkg::ST_LOAD) begin
      o_result.valid       <= i_mem_ready;
      o_result.dest        <= load_dest_reg;
      o_result.data        <= load_data;
      o_result.acc_written <= 1'b0;
    end else if (issue_ok && !is_load && op != vec_pkg::OP_NONE) begin
      o_result.valid       <= 1'b1;
      o_result.dest        <= i_issue.instr[25:21];
      o_result.data        <= (op == vec_pkg::OP_MAC) ? mac_sum : merge_data;
      o_result.acc_written <= (op == vec_pkg::OP_MAC); // RL15
    end else begin
      // Both strobes pulse for one cycle only.
      o_result.valid       <= 1'b0;
      o_result.acc_written <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      // Only the guarded accumulate moves the total.
      o_mac_running_total <= vec_pkg::ACC_RESET;
    end else if (issue_ok && op == vec_pkg::OP_MAC) begin
      o_mac_running_total <= mac_sum; // RL15
    end
  end

endmodule

// file: vec_checker.sv
`timescale 1ns/1ns
module vec_checker (
  input wire logic             i_clk,
  input wire logic             i_rstn,
  input wire vec_pkg::issue_t  i_issue,
  input wire logic             i_mem_ready,
  input wire logic             o_busy,
  input wire logic             o_mem_req,
  input wire logic [31:0]      o_mem_addr,
  input wire vec_pkg::result_t o_result,
  input wire logic [63:0]      o_mac_running_total
);
  logic [10:0] xo;
  logic        go;
  logic        ld;
  logic [31:0] ea;
  logic [63:0] a;
  logic [63:0] b;
  logic [63:0] sx;
  assign xo = i_issue.instr[10:0];
  assign a = i_issue.index_source_reg;
  assign b = i_issue.src_b;
  assign go = i_issue.valid && !o_busy
              && i_issue.instr[31:26] == vec_pkg::PRIMARY_OPC;
  assign ld = go && xo[10:4] == 7'h31 && xo[3:1] != 3'h1
              && xo[3:1] != 3'h5 && xo[3:1] != 3'h7;
  assign ea = (i_issue.instr[20:16] == 5'h00 ? 32'h0
              : i_issue.base_source_reg)
              + (xo[0] ? {25'h0, i_issue.instr[15:11], 2'h0} : a[31:0]);
  assign sx = 64'($signed(32'($signed(a[31:16]) * $signed(b[31:16]) * 2)));
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_load_start: assert property (ld |=> o_mem_req && o_busy)
    else $error("load did not raise its request");
  a_load_addr: assert property (ld |=> o_mem_addr == $past(ea))
    else $error("load address wrong");
  a_req_hold: assert property (o_mem_req && !i_mem_ready
    |=> o_mem_req && $stable(o_mem_addr))
    else $error("request dropped before ready");
  a_load_done: assert property (o_mem_req && i_mem_ready
    |=> o_result.valid && !o_mem_req && !o_busy)
    else $error("load did not finish after ready");
  a_merge_high: assert property (go && xo == vec_pkg::XO_MERGE_HI
    |=> o_result.data == {$past(a[63:32]), $past(b[63:32])})
    else $error("high merge wrong");
  a_merge_low: assert property (go && xo == vec_pkg::XO_MERGE_LO
    |=> o_result.data == {$past(a[31:0]), $past(b[31:0])})
    else $error("low merge wrong");
  a_merge_lohi: assert property (go && xo == vec_pkg::XO_MERGE_LOHI
    |=> o_result.data == {$past(a[31:0]), $past(b[63:32])})
    else $error("low high merge wrong");
  a_merge_hilo: assert property (go && xo == vec_pkg::XO_MERGE_HILO
    |=> o_result.data == {$past(a[63:32]), $past(b[31:0])})
    else $error("high low merge wrong");
  a_mac_sum: assert property (go && xo == vec_pkg::XO_GUARD_MAC
    |=> o_result.acc_written && o_mac_running_total == o_result.data
    && o_result.data == $past(o_mac_running_total) + $past(sx))
    else $error("accumulate wrong");
  cover property (ld ##1 o_mem_req [*3]);
  cover property (go && xo == vec_pkg::XO_GUARD_MAC ##1 go);
  cover property (go && xo == vec_pkg::XO_MERGE_LOHI);
endmodule
bind vec_load_merge_mac vec_checker u_vec_checker (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_issue(i_issue), .i_mem_ready(i_mem_ready),
  .o_busy(o_busy), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
  .o_result(o_result), .o_mac_running_total(o_mac_running_total));

// file: mem_load_model.sv
`timescale 1ns/1ns
module mem_load_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic [31:0] i_word,
  input  wire logic [3:0]  i_delay,
  output logic             o_ready,
  output logic [31:0]      o_rdata
);
  logic [3:0] cnt_reg = 4'h0;
  initial o_ready = 1'b0;
  initial o_rdata = 32'h0;
  // Outside the ready cycle the data lines toggle, so stale data never passes.
  always @(posedge i_clk) begin
    if (i_req && !o_ready && cnt_reg == i_delay) begin
      o_ready <= 1'b1;
      o_rdata <= i_word;
      cnt_reg <= 4'h0;
    end else begin
      o_ready <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ready) cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  logic i_clk, i_rstn, i_le, rdy, busy, req;
  logic [31:0] rdata, word, addr;
  logic [3:0] dly;
  logic [63:0] tot;
  vec_pkg::issue_t iss;
  vec_pkg::result_t res;
  int error_cnt = 0;
  int n_compared = 0;
  vec_load_merge_mac u_vec_load_merge_mac (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_issue(iss), .i_little_endian(i_le), .i_mem_ready(rdy),
    .i_mem_rdata(rdata), .o_busy(busy), .o_mem_req(req), .o_mem_addr(addr),
    .o_result(res), .o_mac_running_total(tot));
  mem_load_model u_mem_load_model (.i_clk(i_clk), .i_req(req),
    .i_word(word), .i_delay(dly), .o_ready(rdy), .o_rdata(rdata));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic vec_pkg::issue_t mk(logic v, logic [10:0] xo,
      logic [4:0] bf, logic [31:0] bs, logic [63:0] a, logic [63:0] b);
    return '{v, {vec_pkg::PRIMARY_OPC, 5'h07, bf, 5'h1F, xo}, bs, a, b};
  endfunction
  task automatic wait_res;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      iss.valid <= 1'b0;
      #1;
      n++;
    end while (res.valid !== 1'b1 && n < 40);
    if (n == 40) begin
      error_cnt++;
      test_done();
    end
    chk("dest", 64'h7, {59'h0, res.dest});
  endtask
  task automatic ld(input logic [10:0] xo, input logic le, input int k);
    logic [31:0] bs, ea, w;
    logic [15:0] h1, h2;
    logic [63:0] ix, e;
    bs = 32'h0001_0000 + k;
    ix = 64'h5A5A_5A5A_0000_0124;
    w = 32'h8A7F_5C91;
    ea = (k[1] ? bs : 32'h0) + (xo[0] ? 32'h7C : ix[31:0]);
    h1 = le ? {w[23:16], w[31:24]} : w[31:16];
    h2 = le ? {w[7:0], w[15:8]} : w[15:0];
    case (xo & 11'h7FE)
      vec_pkg::XO_WHE_X: e = {h1, 16'h0, h2, 16'h0};
      vec_pkg::XO_WHOS_X: e = {{16{h1[15]}}, h1, {16{h2[15]}}, h2};
      vec_pkg::XO_WHOU_X: e = {16'h0, h1, 16'h0, h2};
      vec_pkg::XO_WHSPLAT_X: e = {h1, h1, h2, h2};
      default: e = le ? {2{w[7:0], w[15:8], w[23:16], w[31:24]}} : {w, w};
    endcase
    @(posedge i_clk);
    word <= w;
    dly <= 4'(k % 4);
    i_le <= le;
    iss <= mk(1'b1, xo, k[1] ? 5'h03 : 5'h00, bs, ix, 64'h0);
    @(posedge i_clk);
    iss.valid <= 1'b0;
    #1;
    chk("addr", {32'h0, ea}, {32'h0, addr});
    chk("busy", 64'h1, {63'h0, busy});
    chk("req", 64'h1, {63'h0, req});
    wait_res;
    chk("load", e, res.data);
    chk("idle", 64'h0, {62'h0, busy, req});
  endtask
  task automatic t_loads;
    logic [10:0] t [10];
    t = '{vec_pkg::XO_WHE_D, vec_pkg::XO_WHE_X, vec_pkg::XO_WHOU_X,
      vec_pkg::XO_WHOU_D, vec_pkg::XO_WHOS_D, vec_pkg::XO_WHOS_X,
      vec_pkg::XO_WHSPLAT_X, vec_pkg::XO_WHSPLAT_D, vec_pkg::XO_WWSPLAT_D,
      vec_pkg::XO_WWSPLAT_X};
    for (int k = 0; k < 20; k++) ld(t[k % 10], k >= 10, k);
  endtask
  task automatic t_merge;
    logic [63:0] a, b;
    logic [63:0] e [6];
    logic [10:0] m [6];
    a = 64'h1111_2222_3333_4444;
    b = 64'hAAAA_BBBB_CCCC_DDDD;
    m = '{vec_pkg::XO_MERGE_HI, vec_pkg::XO_MERGE_LO, vec_pkg::XO_MERGE_HILO,
      vec_pkg::XO_MERGE_LOHI, vec_pkg::XO_MERGE_LOHI, vec_pkg::XO_MERGE_HI};
    e = '{{a[63:32], b[63:32]}, {a[31:0], b[31:0]}, {a[63:32], b[31:0]},
      {a[31:0], b[63:32]}, {a[31:0], a[63:32]}, {a[63:32], a[63:32]}};
    for (int i = 0; i < 7; i++) begin
      @(posedge i_clk);
      iss <= mk(i < 6, m[i % 6], 5'h00, 32'h0, a, i >= 4 ? a : b);
      #1;
      if (i > 0) chk("merge", e[i-1], res.data);
    end
    @(posedge i_clk);
    iss <= '{1'b1, {6'h05, 5'h07, 10'h0, 11'h22C}, 32'h0, a, b};
    @(posedge i_clk);
    iss.valid <= 1'b0;
    #1;
    chk("refused", 64'h0, {63'h0, res.valid});
  endtask
  task automatic t_mac;
    logic [63:0] a [2], b [2], acc;
    a = '{64'h7FFF_0123_8000_4567, 64'h0001_0002_4000_FFFF};
    b = '{64'h1234_7FFF_8000_0ABC, 64'h8000_8000_C000_0001};
    acc = 64'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      iss <= mk(i < 2, vec_pkg::XO_GUARD_MAC, 5'h00, 32'h0, a[i%2], b[i%2]);
      #1;
      if (i > 0) begin
        acc = acc + 64'($signed(32'($signed(a[i-1][31:16])
          * $signed(b[i-1][31:16]) * 2)));
        chk("mac", acc, res.data);
        chk("total", acc, tot);
        chk("accw", 64'h1, {63'h0, res.acc_written});
      end
    end
  endtask
  initial begin
    i_rstn = 1'b0;
    iss = '0;
    i_le = 1'b0;
    word = 32'h0;
    dly = 4'h0;
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_mac;
    t_merge;
    t_loads;
    test_done;
  end
endmodule
